// *** core/ppi_edge_det.sv ***
// Per-pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module ppi_edge_det (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Pin and setting
    input wire logic pin_in,
    input wire logic [1:0] edge_sel,
    // Result
    output logic pin_sync,
    output logic edge_hit
);
    logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

    always_comb
    begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // Edges only; a held level never sets the flag again
    always_comb
    begin
        case (edge_sel)
            ppi_pkg::PPI_EDGE_RISE: edge_hit = s2_q & ~s3_q;
            ppi_pkg::PPI_EDGE_FALL: edge_hit = ~s2_q & s3_q;
            ppi_pkg::PPI_EDGE_BOTH: edge_hit = s2_q ^ s3_q;
            default: edge_hit = 1'b0;
        endcase
    end

    assign pin_sync = s2_q;
endmodule : ppi_edge_det
`default_nettype wire

// *** core/ppi_port.sv ***
// Port pin interrupt unit with pin configuration registers
//
// Notes on behaviour
// - Eight pins share one interrupt unit with its own request line.
// - Each pin selects rising, falling, both edges or no interrupt.
// - A matching edge sets the pin's status bit and raises the request if the pin's REG_INT_ENABLE bit is set.
// - Edge detection keeps running in every sleep mode for wake-up.
// - Only edges are detected; levels need external logic.
// - One port-wide choice of CMOS or LVTTL input thresholds.
// - Each pin's input buffer can be disabled in any drive mode.
// - During reset every pin sits in high impedance analog.
// - At reset release the stored reset configuration is loaded.
// - Loaded configuration may put the whole port into pull-down or pull-up.
// - Pin outputs hold their state in low-power modes until changed.
// - Special pin pairs share a selectable input-high reference.
// - Each special pin picks supply-level or regulated high output.
// - Reference can come from the analog global line, making a comparator.
// - Each special pin has an input hysteresis enable.
// - Each pin has a three-bit drive mode; code 000 is high impedance analog.
`timescale 1ns/1ps
`default_nettype none
module ppi_port #(
    parameter int unsigned NUM_PINS = ppi_pkg::NUM_PINS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Nonvolatile reset configuration
    input wire logic [1:0] nv_rst_cfg,
    output logic nv_load_req,
    input wire logic nv_load_ack,
    // Power state
    input wire logic low_power,
    // Pins
    input wire logic [7:0] pin_in,
    // Pad controls
    output logic [7:0] pad_drive_mode_field_0,
    output logic [7:0] pad_drive_mode_field_1,
    output logic [7:0] pad_drive_mode_field_2,
    output logic [7:0] pad_data_out,
    output logic [7:0] pad_inbuf_en,
    output logic pad_lvttl,
    output logic [7:0] special_io_pin_reg_out,
    output logic [7:0] special_io_pin_hyst,
    output logic [7:0] special_io_pin_vref_sel,
    output logic special_io_pin_cmp_mode,
    // Interrupt
    output logic port_interrupt_unit_irq
);
    if (NUM_PINS != 8)
    begin : g_bad_pins
        $error("ppi_port serves eight pins only");
    end

    // Configuration state
    logic [2:0] dm_q [8];
    logic [2:0] dm_d [8];
    logic [15:0] edge_q, edge_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] ien_q, ien_d;
    logic [7:0] inbuf_dis_q, inbuf_dis_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] regout_q, regout_d;
    logic [7:0] hyst_q, hyst_d;
    logic [7:0] vref_q, vref_d;
    logic [7:0] dout_q, dout_d;
    logic [1:0] rcfg_q, rcfg_d;
    logic [7:0] rdata_q, rdata_d;
    ppi_pkg::ppi_ld_state_t ld_q, ld_d;
    logic [7:0] hit;
    logic [7:0] pin_s;

    // Decode of a register address, used by read and write paths
    function automatic logic is_reg(input logic [4:0] a, input logic [4:0] r);
        is_reg = (a == r);
    endfunction : is_reg

    // Detection runs off mclk alone, independent of low_power
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_pin
            ppi_edge_det u_det (
                .mclk(mclk),
                .rst_b(rst_b),
                .pin_in(pin_in[g]),
                .edge_sel(edge_q[2*g+1:2*g]),
                .pin_sync(pin_s[g]),
                .edge_hit(hit[g])
            );
        end
    endgenerate

    // Reset configuration load sequence
    always_comb
    begin
        ld_d = ld_q;
        rcfg_d = rcfg_q;
        case (ld_q)
            ppi_pkg::PPI_LD_IDLE: ld_d = ppi_pkg::PPI_LD_REQ;
            ppi_pkg::PPI_LD_REQ:
            begin
                if (nv_load_ack)
                begin
                    rcfg_d = nv_rst_cfg;
                    ld_d = ppi_pkg::PPI_LD_DONE;
                end
            end
            ppi_pkg::PPI_LD_DONE: ld_d = ppi_pkg::PPI_LD_DONE;
            default: ld_d = ppi_pkg::PPI_LD_IDLE;
        endcase
        if (reg_wr && is_reg(reg_addr, ppi_pkg::REG_RST_CFG))
            rcfg_d = reg_wdata[1:0];
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ld_q <= ppi_pkg::PPI_LD_IDLE;
            rcfg_q <= ppi_pkg::PPI_RCFG_DEFAULT;
        end
        else
        begin
            ld_q <= ld_d;
            rcfg_q <= rcfg_d;
        end
    end

    assign nv_load_req = (ld_q == ppi_pkg::PPI_LD_REQ);

    // Register writes and status
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            dm_d[i] = dm_q[i];
            if (reg_wr && is_reg(reg_addr, ppi_pkg::REG_DM_BASE + 5'(i)))
                dm_d[i] = reg_wdata[2:0];
        end
        edge_d = edge_q;
        ien_d = ien_q;
        inbuf_dis_d = inbuf_dis_q;
        cfg_d = cfg_q;
        regout_d = regout_q;
        hyst_d = hyst_q;
        vref_d = vref_q;
        dout_d = dout_q;
        stat_d = stat_q;
        if (reg_wr)
        begin
            case (reg_addr)
                ppi_pkg::REG_EDGE_LO: edge_d[7:0] = reg_wdata;
                ppi_pkg::REG_EDGE_HI: edge_d[15:8] = reg_wdata;
                ppi_pkg::REG_INT_ENABLE: ien_d = reg_wdata;
                ppi_pkg::REG_INBUF_DIS: inbuf_dis_d = reg_wdata;
                ppi_pkg::REG_PORT_CFG: cfg_d = reg_wdata & 8'h03;
                ppi_pkg::REG_REG_OUT: regout_d = reg_wdata;
                ppi_pkg::REG_HYST: hyst_d = reg_wdata;
                ppi_pkg::REG_VREF_SEL: vref_d = reg_wdata;
                ppi_pkg::REG_DATA_OUT: dout_d = reg_wdata;
                ppi_pkg::REG_INT_CLEAR: stat_d = stat_q & ~reg_wdata;
                default: stat_d = stat_q;
            endcase
        end
        if (reg_rd && is_reg(reg_addr, ppi_pkg::REG_INT_STATUS))
            stat_d = 8'h00;
        // A new edge beats a clear in the same cycle
        stat_d = stat_d | hit;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 8; i++)
                dm_q[i] <= ppi_pkg::DM_RST;
            edge_q <= '0;
            ien_q <= ppi_pkg::RST_BYTE;
            inbuf_dis_q <= ppi_pkg::RST_BYTE;
            cfg_q <= ppi_pkg::RST_BYTE;
            regout_q <= ppi_pkg::RST_BYTE;
            hyst_q <= ppi_pkg::RST_BYTE;
            vref_q <= ppi_pkg::RST_BYTE;
            dout_q <= ppi_pkg::RST_BYTE;
            stat_q <= ppi_pkg::RST_BYTE;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
                dm_q[i] <= dm_d[i];
            edge_q <= edge_d;
            ien_q <= ien_d;
            inbuf_dis_q <= inbuf_dis_d;
            cfg_q <= cfg_d;
            regout_q <= regout_d;
            hyst_q <= hyst_d;
            vref_q <= vref_d;
            dout_q <= dout_d;
            stat_q <= stat_d;
        end
    end

    // Read data, one cycle after the strobe
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ppi_pkg::REG_INT_STATUS: rdata_d = stat_q;
                ppi_pkg::REG_INT_ENABLE: rdata_d = ien_q;
                ppi_pkg::REG_EDGE_LO: rdata_d = edge_q[7:0];
                ppi_pkg::REG_EDGE_HI: rdata_d = edge_q[15:8];
                ppi_pkg::REG_INBUF_DIS: rdata_d = inbuf_dis_q;
                ppi_pkg::REG_PORT_CFG: rdata_d = cfg_q;
                ppi_pkg::REG_REG_OUT: rdata_d = regout_q;
                ppi_pkg::REG_HYST: rdata_d = hyst_q;
                ppi_pkg::REG_VREF_SEL: rdata_d = vref_q;
                ppi_pkg::REG_RST_CFG: rdata_d = {6'h00, rcfg_q};
                ppi_pkg::REG_DATA_OUT: rdata_d = dout_q;
                ppi_pkg::REG_PIN_IN: rdata_d = pin_s & ~inbuf_dis_q;
                default:
                begin
                    for (int i = 0; i < 8; i++)
                        if (is_reg(reg_addr, ppi_pkg::REG_DM_BASE + 5'(i)))
                            rdata_d = {5'h00, dm_q[i]};
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;

    // Pad drive. Reset clears every register, so pads fall to analog
    // high impedance; low_power gates nothing, so pad state is held.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            logic [2:0] m;
            m = dm_q[i];
            if (ld_q == ppi_pkg::PPI_LD_DONE && m == ppi_pkg::PPI_DM_HIZ_ANALOG)
            begin
                if (rcfg_q == ppi_pkg::PPI_RCFG_PULL_DOWN)
                    m = ppi_pkg::PPI_DM_RES_DOWN;
                else if (rcfg_q == ppi_pkg::PPI_RCFG_PULL_UP)
                    m = ppi_pkg::PPI_DM_RES_UP;
            end
            if (ld_q != ppi_pkg::PPI_LD_DONE)
                m = ppi_pkg::PPI_DM_HIZ_ANALOG;
            pad_drive_mode_field_0[i] = m[0];
            pad_drive_mode_field_1[i] = m[1];
            pad_drive_mode_field_2[i] = m[2];
            pad_inbuf_en[i] = (m != ppi_pkg::PPI_DM_HIZ_ANALOG) & ~inbuf_dis_q[i];
        end
    end

    assign pad_data_out = (ld_q == ppi_pkg::PPI_LD_DONE) ? dout_q : 8'h00;
    assign pad_lvttl = cfg_q[ppi_pkg::CFG_LVTTL_BIT];
    assign special_io_pin_cmp_mode = cfg_q[ppi_pkg::CFG_CMP_BIT];
    assign special_io_pin_reg_out = regout_q;
    assign special_io_pin_hyst = hyst_q;
    assign special_io_pin_vref_sel = vref_q;

    // Level request while an enabled pending bit stands
    assign port_interrupt_unit_irq = |(stat_q & ien_q);
endmodule : ppi_port
`default_nettype wire

// *** inc/ppi_pkg.sv ***
// Package for the port pin interrupt and configuration block
package ppi_pkg;
    localparam int unsigned NUM_PINS = 8;
    localparam int unsigned NUM_PAIRS = NUM_PINS / 2;
    localparam int unsigned DM_W = 3;
    localparam int unsigned ADDR_W = 5;

    // Register offsets
    localparam logic [4:0] REG_INT_STATUS = 5'h00;
    localparam logic [4:0] REG_INT_CLEAR = 5'h01;
    localparam logic [4:0] REG_INT_ENABLE = 5'h02;
    localparam logic [4:0] REG_EDGE_LO = 5'h03;
    localparam logic [4:0] REG_EDGE_HI = 5'h04;
    localparam logic [4:0] REG_INBUF_DIS = 5'h05;
    localparam logic [4:0] REG_PORT_CFG = 5'h06;
    localparam logic [4:0] REG_REG_OUT = 5'h07;
    localparam logic [4:0] REG_HYST = 5'h08;
    localparam logic [4:0] REG_VREF_SEL = 5'h09;
    localparam logic [4:0] REG_RST_CFG = 5'h0A;
    localparam logic [4:0] REG_DATA_OUT = 5'h0B;
    localparam logic [4:0] REG_PIN_IN = 5'h0C;
    localparam logic [4:0] REG_DM_BASE = 5'h10;

    // Field positions in REG_PORT_CFG
    localparam int unsigned CFG_LVTTL_BIT = 0;
    localparam int unsigned CFG_CMP_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] DM_RST = 3'h0;
    localparam logic [1:0] EDGE_RST = 2'h0;

    typedef enum logic [1:0] {
        PPI_EDGE_NONE = 2'b00,
        PPI_EDGE_RISE = 2'b01,
        PPI_EDGE_FALL = 2'b10,
        PPI_EDGE_BOTH = 2'b11
    } ppi_edge_t;

    typedef enum logic [2:0] {
        PPI_DM_HIZ_ANALOG = 3'b000,
        PPI_DM_HIZ_DIGITAL = 3'b001,
        PPI_DM_RES_UP = 3'b010,
        PPI_DM_RES_DOWN = 3'b011,
        PPI_DM_OD_LOW = 3'b100,
        PPI_DM_OD_HIGH = 3'b101,
        PPI_DM_STRONG = 3'b110,
        PPI_DM_RES_BOTH = 3'b111
    } ppi_dm_t;

    typedef enum logic [1:0] {
        PPI_RCFG_DEFAULT = 2'b00,
        PPI_RCFG_PULL_DOWN = 2'b01,
        PPI_RCFG_PULL_UP = 2'b10
    } ppi_rcfg_t;

    typedef enum logic [1:0] {
        PPI_VREF_HALF_SUPPLY = 2'b00,
        PPI_VREF_40PCT_SUPPLY = 2'b01,
        PPI_VREF_HALF_EXT = 2'b10,
        PPI_VREF_FULL_EXT = 2'b11
    } ppi_vref_t;

    typedef enum logic [1:0] {
        PPI_LD_IDLE = 2'b00,
        PPI_LD_REQ = 2'b01,
        PPI_LD_DONE = 2'b10
    } ppi_ld_state_t;
endpackage : ppi_pkg

// *** test/ppi_pin_env.sv ***
// Model of the pins and the nonvolatile reset store
`timescale 1ns/1ps
`default_nettype none
module ppi_pin_env (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Bench commands
    input wire logic [7:0] pin_level,
    input wire logic [1:0] stored_cfg,
    input wire logic [2:0] ack_delay,
    // Device side
    input wire logic nv_load_req,
    output logic [7:0] pin_in,
    output logic [1:0] nv_rst_cfg,
    output logic nv_load_ack
);
    logic [2:0] wait_q;
    assign pin_in = pin_level;
    // Store bus is undriven outside a load, so show junk
    assign nv_rst_cfg = nv_load_req ? stored_cfg : ~stored_cfg;
    assign nv_load_ack = nv_load_req && wait_q == ack_delay;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            wait_q <= 3'h0;
        else
            wait_q <= nv_load_req ? wait_q + 3'h1 : 3'h0;
endmodule : ppi_pin_env
`default_nettype wire

// *** test/ppi_port_bench.sv ***
// Self-checking bench for the port pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module ppi_port_bench;
    logic mclk, rst_b, reg_wr, reg_rd, low_power, nv_load_req, nv_load_ack, pad_lvttl;
    logic special_io_pin_cmp_mode, port_interrupt_unit_irq;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_in, pins, pad_data_out, pad_inbuf_en, st, en, d, c, nxt, old;
    logic [7:0] pad_drive_mode_field_0, pad_drive_mode_field_1, pad_drive_mode_field_2;
    logic [7:0] special_io_pin_reg_out, special_io_pin_hyst, special_io_pin_vref_sel;
    logic [1:0] nv_rst_cfg, stored, m;
    logic [2:0] dly;
    logic [15:0] e;
    logic [7:0] v [6];
    logic [4:0] ra [6] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0B};
    int n_errors = 0;
    int n_checks = 0;
    int k, i;

    ppi_port u_dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nv_rst_cfg,
        .nv_load_req, .nv_load_ack, .low_power, .pin_in, .pad_drive_mode_field_0, .pad_drive_mode_field_1,
        .pad_drive_mode_field_2, .pad_data_out, .pad_inbuf_en, .pad_lvttl, .special_io_pin_reg_out,
        .special_io_pin_hyst, .special_io_pin_vref_sel, .special_io_pin_cmp_mode, .port_interrupt_unit_irq);
    ppi_pin_env u_env (.mclk, .rst_b, .pin_level(pins), .stored_cfg(stored), .ack_delay(dly),
        .nv_load_req, .pin_in, .nv_rst_cfg, .nv_load_ack);

    always #5 mclk = ~mclk;

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] w);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] r);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask : rd

    task automatic do_reset(input logic [1:0] cf);
        @(posedge mclk);
        rst_b <= 1'b0;
        stored <= cf;
        repeat (6) @(posedge mclk);
        chk("dm in reset", pad_drive_mode_field_0 | pad_drive_mode_field_1 | pad_drive_mode_field_2, 8'h00);
        rst_b <= 1'b1;
        for (i = 0; i < 20 && (i < 2 || nv_load_req); i++)
        begin
            @(posedge mclk);
            #1;
        end
        chk("load req", nv_load_req, 8'h00);
        rd(ppi_pkg::REG_RST_CFG, d);
        chk("rst cfg", d, {6'h00, cf});
        chk("pull b0", pad_drive_mode_field_0, cf == 2'h1 ? 8'hFF : 8'h00);
        chk("pull b1", pad_drive_mode_field_1, cf != 2'h0 ? 8'hFF : 8'h00);
    endtask : do_reset

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        low_power = 1'b0;
        pins = 8'h00;
        stored = 2'h0;
        dly = 3'h0;
        void'($urandom(38047));
        for (k = 0; k < 3; k++)
        begin
            dly <= 3'(k);
            do_reset(2'(k));
        end
        wr(ppi_pkg::REG_RST_CFG, 8'h01);
        rd(ppi_pkg::REG_RST_CFG, d);
        chk("rst cfg sw", d, 8'h01);
        chk("sw pull b0", pad_drive_mode_field_0, 8'hFF);
        // Digital input mode keeps pulls off, as regulated outputs need
        for (k = 0; k < 8; k++)
            wr(ppi_pkg::REG_DM_BASE + 5'(k), 8'h01);
        rd(ppi_pkg::REG_DM_BASE + 5'h03, d);
        chk("dm read", d, 8'h01);
        chk("dm b0", pad_drive_mode_field_0, 8'hFF);
        chk("dm b21", pad_drive_mode_field_1 | pad_drive_mode_field_2, 8'h00);
        rd(5'h1F, d);
        chk("unmapped", d, 8'h00);
        for (k = 0; k < 6; k++)
        begin
            v[k] = 8'($urandom);
            wr(ra[k], v[k]);
            rd(ra[k], d);
            chk("reg rw", d, k == 1 ? v[k] & 8'h03 : v[k]);
        end
        chk("inbuf", pad_inbuf_en, ~v[0]);
        chk("lvttl", pad_lvttl, {7'h00, v[1][0]});
        chk("cmp", special_io_pin_cmp_mode, {7'h00, v[1][1]});
        chk("reg out", special_io_pin_reg_out, v[2]);
        chk("hyst", special_io_pin_hyst, v[3]);
        chk("vref", special_io_pin_vref_sel, v[4]);
        chk("dout", pad_data_out, v[5]);
        @(posedge mclk);
        pins <= 8'($urandom);
        repeat (4) @(posedge mclk);
        rd(ppi_pkg::REG_PIN_IN, d);
        chk("pin in", d, pins & ~v[0]);
        wr(ppi_pkg::REG_INBUF_DIS, 8'h00);
        old = pins;
        st = 8'h00;
        for (k = 0; k < 40; k++)
        begin
            e = 16'($urandom);
            en = 8'($urandom);
            nxt = 8'($urandom);
            wr(ppi_pkg::REG_EDGE_LO, e[7:0]);
            wr(ppi_pkg::REG_EDGE_HI, e[15:8]);
            wr(ppi_pkg::REG_INT_ENABLE, en);
            @(posedge mclk);
            pins <= nxt;
            low_power <= k[0];
            for (i = 0; i < 8; i++)
            begin
                m = e[2*i+:2];
                if ((m[0] && !old[i] && nxt[i]) || (m[1] && old[i] && !nxt[i]))
                    st[i] = 1'b1;
            end
            old = nxt;
            repeat (5) @(posedge mclk);
            #1 chk("irq", port_interrupt_unit_irq, {7'h00, |(st & en)});
            if (k % 3 == 0)
            begin
                c = 8'($urandom);
                wr(ppi_pkg::REG_INT_CLEAR, c);
                st = st & ~c;
            end
            rd(ppi_pkg::REG_INT_STATUS, d);
            chk("status", d, st);
            st = 8'h00;
            rd(ppi_pkg::REG_INT_STATUS, d);
            chk("status clr", d, 8'h00);
        end
        wr(ppi_pkg::REG_INT_ENABLE, 8'h00);
        report_and_stop();
    end

    initial
    begin
        #300000;
        n_errors++;
        report_and_stop();
    end
endmodule : ppi_port_bench
`default_nettype wire

// *** test/ppi_port_props.sv ***
// Checker for the port pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module ppi_port_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Load and power
    input wire logic nv_load_req,
    input wire logic nv_load_ack,
    input wire logic low_power,
    // Pads and interrupt
    input wire logic [7:0] pad_drive_mode_field_0,
    input wire logic [7:0] pad_drive_mode_field_1,
    input wire logic [7:0] pad_drive_mode_field_2,
    input wire logic [7:0] pad_data_out,
    input wire logic [7:0] pad_inbuf_en,
    input wire logic [7:0] special_io_pin_reg_out,
    input wire logic port_interrupt_unit_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire [7:0] any_dm = pad_drive_mode_field_0 | pad_drive_mode_field_1 | pad_drive_mode_field_2;

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    a_pads_analog: assert property (nv_load_req |-> any_dm == 8'h00 && pad_inbuf_en == 8'h00)
        else $error("pads left analog before load done");
    a_load_holds: assert property (nv_load_req && !nv_load_ack |=> nv_load_req)
        else $error("load request dropped early");
    a_load_ends: assert property (nv_load_req && nv_load_ack |=> !nv_load_req)
        else $error("load request stuck after ack");
    a_analog_no_inbuf: assert property ((~any_dm & pad_inbuf_en) == 8'h00)
        else $error("input buffer on in analog mode");
    a_mask_kills_irq: assert property (reg_wr && reg_addr == ppi_pkg::REG_INT_ENABLE && reg_wdata == 8'h00
        |=> !port_interrupt_unit_irq)
        else $error("irq high with all masked");
    a_out_level: assert property (reg_wr && reg_addr == ppi_pkg::REG_REG_OUT
        |=> special_io_pin_reg_out == $past(reg_wdata))
        else $error("output level select not taken");
    a_sleep_hold: assert property (low_power && !reg_wr |=> $stable(pad_data_out))
        else $error("pin output moved in low power");
endmodule : ppi_port_chk
bind ppi_port ppi_port_chk u_chk (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nv_load_req, .nv_load_ack, .low_power, .pad_drive_mode_field_0, .pad_drive_mode_field_1,
    .pad_drive_mode_field_2, .pad_data_out, .pad_inbuf_en, .special_io_pin_reg_out, .port_interrupt_unit_irq);
`default_nettype wire
